// ===== common/uln_pkg.sv
// package: uart line decoder constants and types
package uln_pkg;
    localparam int LINES = 8;
    localparam int BUSES = 4;
    localparam logic [31:0] CLK_HZ = 32'h02FA_F080;
    localparam logic [31:0] HALF_BIT = CLK_HZ >> 1;
    localparam logic [31:0] RATE_MIN = 32'h0000_012C;
    localparam logic [31:0] RATE_MAX = 32'h0131_2D00;
    localparam logic [31:0] RATE_RST = 32'h0000_2580;
    localparam logic [31:0] US_PER_S = 32'h000F_4240;
    localparam logic [31:0] US_CYC = CLK_HZ / US_PER_S;
    localparam logic [31:0] IDLE_GAP_GROUPING_MIN_US = 32'h0000_0001;
    localparam logic [31:0] IDLE_GAP_GROUPING_MAX_US = US_PER_S;
    localparam logic [31:0] IDLE_GAP_GROUPING_RST_US = 32'h0000_0271;
    localparam logic [31:0] POS_MIN = 32'h0000_0001;
    localparam logic [31:0] POS_MAX = 32'h0000_1000;
    // register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_IDLE_GAP_GROUPING = 8'h08;
    localparam logic [7:0] OFS_END_PATTERN_GROUPING = 8'h0C;
    localparam logic [7:0] OFS_TRIG = 8'h40;
    localparam logic [7:0] OFS_PAT = 8'h44;
    localparam logic [7:0] OFS_STAT = 8'h48;
    localparam logic [7:0] OFS_MASK = 8'h4C;
    localparam logic [7:0] OFS_LAST = 8'h60;
    // line config fields
    localparam int CFG_ORDER = 0;
    localparam int CFG_PKT = 1;
    localparam int CFG_PAR = 3;
    localparam int CFG_POL = 6;
    localparam int CFG_STOP = 7;
    localparam int CFG_WID = 9;
    localparam int CFG_TXSRC = 13;
    localparam int CFG_RXSRC = 16;
    localparam logic [31:0] CFG_RST = 32'h0001_1004;
    // trigger config fields
    localparam int TRG_TYPE = 0;
    localparam int TRG_BUS = 3;
    localparam int TRG_LINE = 5;
    localparam int TRG_POS = 8;
    localparam logic [31:0] TRIG_RST = 32'h0000_0100;
    localparam int STAT_W = 17;
    localparam int STAT_TRIG = 16;
    localparam logic low_bit_first = 1'b0;
    localparam logic high_bit_first = 1'b1;
    localparam logic idle_at_high_level = 1'b0;
    localparam logic idle_at_low_level = 1'b1;
    typedef enum logic [2:0] {parity_none, parity_odd, parity_even,
        parity_always_one, parity_always_zero,
        parity_unchecked} uln_par_t;
    typedef enum logic [1:0] {one_stop, one_and_half_stop,
        two_stop} uln_stop_t;
    typedef enum logic [1:0] {no_grouping, end_pattern_grouping,
        idle_gap_grouping} uln_pkt_t;
    typedef enum logic [2:0] {trigger_on_start, trigger_on_packet_begin,
        trigger_on_data, trigger_on_break,
        trigger_on_bad_stop} uln_trig_t;
    typedef enum logic [2:0] {st_idle, st_start, st_data, st_par,
        st_stop} uln_rx_t;
endpackage

// ===== rtl/uln_top.sv
// uart line decoder: four buses of tx/rx lines behind ahb-lite
// Contract
// - bit rate 300 to 20000000 bps, 9600 after reset
// - words assembled low bit first or high bit first, low first default
// - grouping none, end pattern or idle timeout; timeout default
// - end pattern seen opens new packet at next start bit
// - line idle for timeout opens new packet at next start bit
// - packet timeout 1 us to 1 s, default 625 us
// - parity none, odd, even, always one, always zero; none default
// - unchecked parity keeps the parity slot but ignores its value
// - idle is logic 1, start bit logic 0, after polarity
// - polarity idle high or idle low, idle high default
// - one, one and a half or two stop bits, one default
// - 5 to 8 data bits, default 8; 9 only without parity
// - tx and rx lines decoded independently, each with own source
// - four decoder buses, each with its own full settings
// - trigger pattern read high bit first whatever the bit order
// - trigger on start, packet start, pattern, break or bad stop
// - trigger skips 1 to 4096 leading words before matching, default 1
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module uln_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // probe channels
    input wire logic [uln_pkg::LINES-1:0] chan_in,
    // events
    output logic irq,
    output logic trig_out
);
    import uln_pkg::*;

    function automatic logic [31:0] uln_clamp(
        input logic [31:0] v,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        if (v < lo) begin
            return lo;
        end
        return (v > hi) ? hi : v;
    endfunction

    logic [31:0] cfg_reg [BUSES];
    logic [31:0] rate_reg [BUSES];
    logic [31:0] idle_gap_grouping_reg [BUSES];
    logic [31:0] end_pattern_grouping_reg [BUSES];
    logic [31:0] trig_reg;
    logic [31:0] pat_reg;
    logic [STAT_W-1:0] stat_reg;
    logic [STAT_W-1:0] mask_reg;
    logic [STAT_W-1:0] stat_next;
    logic [STAT_W-1:0] stat_clr;
    logic wr_reg;
    logic [7:0] wa_reg;
    logic [31:0] rd;
    logic [LINES-1:0] chan_s1_reg;
    logic [LINES-1:0] chan_s2_reg;
    logic [LINES-1:0] ev_word;
    logic [LINES-1:0] ev_err;
    logic [LINES-1:0] ev_start;
    logic [LINES-1:0] ev_pkt;
    logic [LINES-1:0] ev_brk;
    logic [LINES-1:0] ev_bstop;
    logic [LINES-1:0] ev_match;
    logic [LINES-1:0] last_err;
    logic [8:0] last_word [LINES];
    logic [2:0] tsel;
    logic trig_ev;
    uln_trig_t ttype;

    // bus: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
        end else if (hready) begin
            wr_reg <= hsel && htrans[1] && hwrite && hsize == 3'b010;
            wa_reg <= haddr[7:0];
        end
    end

    always_comb begin
        rd = 32'h0000_0000;
        if (haddr[7:6] == 2'b00) begin
            case ({4'h0, haddr[3:0]})
                OFS_CFG: rd = cfg_reg[haddr[5:4]];
                OFS_RATE: rd = rate_reg[haddr[5:4]];
                OFS_IDLE_GAP_GROUPING: rd = idle_gap_grouping_reg[haddr[5:4]];
                OFS_END_PATTERN_GROUPING: rd = end_pattern_grouping_reg[haddr[5:4]];
                default: rd = 32'h0000_0000;
            endcase
        end else if (haddr[7:5] == OFS_LAST[7:5]) begin
            rd = {22'h00_0000, last_err[haddr[4:2]],
                last_word[haddr[4:2]]};
        end else begin
            case (haddr[7:0])
                OFS_TRIG: rd = trig_reg;
                OFS_PAT: rd = pat_reg;
                OFS_STAT: rd = {15'h0000, stat_reg};
                OFS_MASK: rd = {15'h0000, mask_reg};
                default: rd = 32'h0000_0000;
            endcase
        end
    end

    // read data registered in the address phase, valid in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= (hsel && htrans[1] && !hwrite) ? rd : 32'h0000_0000;
        end
    end

    // out-of-range writes are clamped so the decoder never stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int b = 0; b < BUSES; b++) begin
                cfg_reg[b] <= CFG_RST;
                rate_reg[b] <= RATE_RST;
                idle_gap_grouping_reg[b] <= IDLE_GAP_GROUPING_RST_US;
                end_pattern_grouping_reg[b] <= 32'h0000_0000;
            end
            trig_reg <= TRIG_RST;
            pat_reg <= 32'h0000_0000;
            mask_reg <= '0;
        end else if (wr_reg) begin
            if (wa_reg[7:6] == 2'b00) begin
                case ({4'h0, wa_reg[3:0]})
                    OFS_CFG: cfg_reg[wa_reg[5:4]] <= hwdata;
                    OFS_RATE: rate_reg[wa_reg[5:4]] <=
                        uln_clamp(hwdata, RATE_MIN, RATE_MAX);
                    OFS_IDLE_GAP_GROUPING: idle_gap_grouping_reg[wa_reg[5:4]] <=
                        uln_clamp(hwdata, IDLE_GAP_GROUPING_MIN_US, IDLE_GAP_GROUPING_MAX_US);
                    default: end_pattern_grouping_reg[wa_reg[5:4]] <= hwdata;
                endcase
            end else if (wa_reg == OFS_TRIG) begin
                trig_reg <= {hwdata[31:21],
                    13'(uln_clamp({19'h0_0000, hwdata[20:8]},
                    POS_MIN, POS_MAX)), hwdata[7:0]};
            end else if (wa_reg == OFS_PAT) begin
                pat_reg <= hwdata;
            end else if (wa_reg == OFS_MASK) begin
                mask_reg <= hwdata[STAT_W-1:0];
            end
        end
    end

    // two-flop synchroniser for the probe channels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // idle-high level, so release does not look like a start edge
            chan_s1_reg <= '1;
            chan_s2_reg <= '1;
        end else begin
            chan_s1_reg <= chan_in;
            chan_s2_reg <= chan_s1_reg;
        end
    end

    // line l: bus l/2, tx when l is even, rx when odd
    for (genvar l = 0; l < LINES; l++) begin : g_line
        logic [31:0] cfg;
        logic [2:0] src;
        logic lvl;
        logic [3:0] wid;
        uln_par_t par;
        uln_pkt_t mode;
        logic [32:0] sum;
        logic tick;
        logic [31:0] tcyc;
        logic last_stop;
        uln_rx_t st_reg;
        logic [31:0] acc_reg;
        logic [3:0] bit_reg;
        logic [8:0] sh_reg;
        logic xor_reg;
        logic perr_reg;
        logic serr_reg;
        logic stop2_reg;
        logic lvl_d_reg;
        logic word_v_reg;
        logic start_v_reg;
        logic [8:0] word_reg;
        logic err_reg;
        logic bstop_reg;
        logic [31:0] idle_reg;
        logic pend_reg;
        logic pkt_v_reg;
        logic [12:0] idx_reg;
        logic match_reg;

        assign cfg = cfg_reg[l/2];
        assign src = (l % 2 == 1) ? cfg[CFG_RXSRC+:3]
            : cfg[CFG_TXSRC+:3];
        assign lvl = chan_s2_reg[src] ^ cfg[CFG_POL];
        assign par = uln_par_t'(cfg[CFG_PAR+:3]);
        assign mode = uln_pkt_t'(cfg[CFG_PKT+:2]);
        assign sum = {1'b0, acc_reg} + {1'b0, rate_reg[l/2]};
        assign tick = sum >= {1'b0, CLK_HZ};
        assign tcyc = 32'(idle_gap_grouping_reg[l/2] * US_CYC);
        assign last_stop = !stop2_reg
            ? uln_stop_t'(cfg[CFG_STOP+:2]) != two_stop : 1'b1;

        always_comb begin
            wid = cfg[CFG_WID+:4];
            if (wid < 4'h5) begin
                wid = 4'h5;
            end
            if (wid > 4'h8) begin
                wid = (par == parity_none) ? 4'h9 : 4'h8;
            end
        end

        // frame receiver
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                st_reg <= st_idle;
                acc_reg <= 32'h0000_0000;
                bit_reg <= 4'h0;
                sh_reg <= 9'h000;
                xor_reg <= 1'b0;
                perr_reg <= 1'b0;
                serr_reg <= 1'b0;
                stop2_reg <= 1'b0;
                lvl_d_reg <= 1'b1;
                word_v_reg <= 1'b0;
                start_v_reg <= 1'b0;
                word_reg <= 9'h000;
                err_reg <= 1'b0;
                bstop_reg <= 1'b0;
            end else begin
                lvl_d_reg <= lvl;
                word_v_reg <= 1'b0;
                start_v_reg <= 1'b0;
                acc_reg <= tick ? 32'(sum - {1'b0, CLK_HZ}) : sum[31:0];
                unique case (st_reg)
                    st_idle: begin
                        if (lvl_d_reg && !lvl) begin
                            acc_reg <= HALF_BIT;
                            st_reg <= st_start;
                            start_v_reg <= 1'b1;
                        end
                    end
                    st_start: begin
                        if (tick) begin
                            // a glitch that is high again at mid-bit
                            st_reg <= lvl ? st_idle : st_data;
                            bit_reg <= 4'h0;
                            sh_reg <= 9'h000;
                            xor_reg <= 1'b0;
                            perr_reg <= 1'b0;
                            serr_reg <= 1'b0;
                            stop2_reg <= 1'b0;
                        end
                    end
                    st_data: begin
                        if (tick) begin
                            sh_reg <= cfg[CFG_ORDER] == high_bit_first
                                ? {sh_reg[7:0], lvl}
                                : {lvl, sh_reg[8:1]};
                            xor_reg <= xor_reg ^ lvl;
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg == wid - 4'h1) begin
                                st_reg <= (par == parity_none)
                                    ? st_stop : st_par;
                            end
                        end
                    end
                    st_par: begin
                        if (tick) begin
                            case (par)
                                parity_odd: perr_reg <= !(xor_reg ^ lvl);
                                parity_even: perr_reg <= xor_reg ^ lvl;
                                parity_always_one: perr_reg <= !lvl;
                                parity_always_zero: perr_reg <= lvl;
                                default: perr_reg <= 1'b0;
                            endcase
                            st_reg <= st_stop;
                        end
                    end
                    st_stop: begin
                        if (tick) begin
                            if (!last_stop) begin
                                stop2_reg <= 1'b1;
                                serr_reg <= !lvl;
                            end else begin
                                st_reg <= st_idle;
                                word_v_reg <= 1'b1;
                                word_reg <= cfg[CFG_ORDER] == high_bit_first
                                    ? sh_reg
                                    : sh_reg >> (4'h9 - wid);
                                err_reg <= perr_reg || serr_reg || !lvl;
                                bstop_reg <= serr_reg || !lvl;
                            end
                        end
                    end
                endcase
            end
        end

        // packet grouping and pattern position
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                idle_reg <= 32'h0000_0000;
                pend_reg <= 1'b1;
                pkt_v_reg <= 1'b0;
                idx_reg <= 13'h0000;
                match_reg <= 1'b0;
            end else begin
                pkt_v_reg <= 1'b0;
                match_reg <= 1'b0;
                if (st_reg != st_idle) begin
                    idle_reg <= 32'h0000_0000;
                end else if (idle_reg != 32'hFFFF_FFFF) begin
                    idle_reg <= idle_reg + 32'h0000_0001;
                end
                if (mode == idle_gap_grouping && idle_reg >= tcyc) begin
                    pend_reg <= 1'b1;
                end
                if (word_v_reg) begin
                    if (idx_reg != 13'h1FFF) begin
                        idx_reg <= idx_reg + 13'h0001;
                    end
                    if (mode == end_pattern_grouping
                        && word_reg == end_pattern_grouping_reg[l/2][8:0]) begin
                        pend_reg <= 1'b1;
                    end
                    // pattern is plain binary value, i.e. high bit first
                    match_reg <= idx_reg == trig_reg[TRG_POS+:13]
                        && word_reg == pat_reg[8:0];
                end
                if (start_v_reg) begin
                    pend_reg <= 1'b0;
                    if (pend_reg && mode != no_grouping) begin
                        pkt_v_reg <= 1'b1;
                        idx_reg <= 13'h0000;
                    end
                end
            end
        end

        assign ev_word[l] = word_v_reg;
        assign ev_err[l] = word_v_reg && err_reg;
        assign ev_bstop[l] = word_v_reg && bstop_reg;
        assign ev_brk[l] = word_v_reg && bstop_reg && word_reg == 9'h000;
        assign ev_start[l] = start_v_reg;
        assign ev_pkt[l] = pkt_v_reg;
        assign ev_match[l] = match_reg;
        assign last_word[l] = word_reg;
        assign last_err[l] = err_reg;
    end

    // trigger selection
    assign tsel = {trig_reg[TRG_BUS+:2], trig_reg[TRG_LINE]};
    assign ttype = uln_trig_t'(trig_reg[TRG_TYPE+:3]);

    always_comb begin
        case (ttype)
            trigger_on_start: trig_ev = ev_start[tsel];
            trigger_on_packet_begin: trig_ev = ev_pkt[tsel];
            trigger_on_data: trig_ev = ev_match[tsel];
            trigger_on_break: trig_ev = ev_brk[tsel];
            trigger_on_bad_stop: trig_ev = ev_bstop[tsel];
            default: trig_ev = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_out <= 1'b0;
        end else begin
            trig_out <= trig_ev;
        end
    end

    // sticky status: a new event beats a write-one clear
    assign stat_clr = (wr_reg && wa_reg == OFS_STAT)
        ? hwdata[STAT_W-1:0] : '0;
    assign stat_next = (stat_reg & ~stat_clr)
        | {trig_ev, ev_err, ev_word};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= stat_next;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    a_rate_reset: assert property (@(posedge hclk)
        disable iff (!hresetn) $rose(hresetn) |->
        rate_reg[0] == RATE_RST && idle_gap_grouping_reg[0] == IDLE_GAP_GROUPING_RST_US)
        else $error("bit rate or timeout not at reset value");
    a_mid_sample: assert property (@(posedge hclk)
        disable iff (!hresetn)
        g_line[0].st_reg == st_idle && g_line[0].lvl_d_reg
        && !g_line[0].lvl |=> g_line[0].acc_reg == HALF_BIT
        && g_line[0].st_reg == st_start)
        else $error("start edge did not restart half-bit phase");
    a_stop_flag: assert property (@(posedge hclk)
        disable iff (!hresetn)
        g_line[0].st_reg == st_stop && g_line[0].tick
        && g_line[0].last_stop && !g_line[0].lvl
        |=> ev_bstop[0] && ev_err[0])
        else $error("low stop bit not flagged");
    a_packet_open: assert property (@(posedge hclk)
        disable iff (!hresetn)
        ev_pkt[0] |-> $past(g_line[0].pend_reg)
        && $past(ev_start[0]))
        else $error("packet opened without pending gap or end word");
    a_no_group: assert property (@(posedge hclk)
        disable iff (!hresetn)
        $past(g_line[0].mode) == no_grouping |-> !ev_pkt[0])
        else $error("packet event while grouping is off");
    a_width_nine: assert property (@(posedge hclk)
        disable iff (!hresetn)
        g_line[0].par != parity_none |-> g_line[0].wid <= 4'h8)
        else $error("nine data bits used with parity");
    a_trig_start: assert property (@(posedge hclk)
        disable iff (!hresetn)
        ttype == trigger_on_start && ev_start[tsel] |=> trig_out)
        else $error("start trigger missed");
    a_set_wins: assert property (@(posedge hclk)
        disable iff (!hresetn)
        ev_word[0] && stat_clr[0] |=> stat_reg[0] ##1 irq || !mask_reg[0])
        else $error("word event lost to clear");
    c_word_err: cover property (@(posedge hclk) ev_err[0]);
    c_packet: cover property (@(posedge hclk) ev_pkt[0]);
    c_trigger: cover property (@(posedge hclk) trig_out ##1 irq);
endmodule
`default_nettype wire

// ===== testbench/uart_line_decoder_bench.sv
// self-checking bench for the uart line decoder
`timescale 1ns/10ps
`default_nettype none
module uart_line_decoder_bench;
    import uln_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic trig_out;
    logic [31:0] hrdata;
    logic [7:0] chan;
    logic trig_seen = 1'b0;
    int n_errors = 0;
    int num_checks = 0;
    // parity bit sent and error expected for modes 1..5 with data 0x03
    int pb [6] = '{0, 0, 0, 0, 0, 1};
    logic pe [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        if (trig_out === 1'b1) begin
            trig_seen <= 1'b1;
        end
    end
    uln_line_drv drv (.chan(chan));
    uln_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .chan_in(chan), .irq(irq),
        .trig_out(trig_out));
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0000_0000, q);
        chk(q, e);
    endtask
    task wd(input int ch, input logic [8:0] v, input int nb, input int p,
            input logic [1:0] st, input int ns, input logic [7:0] a,
            input logic [31:0] e);
        drv.send(ch, v, nb, p, st, ns);
        rc(a, e);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // the whole sequence needs well under half this span
    initial begin
        #1_500_000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rc(OFS_CFG, 32'h0001_1004);
        rc(OFS_RATE, 32'h0000_2580);
        rc(OFS_IDLE_GAP_GROUPING, 32'h0000_0271);
        rc(OFS_TRIG, 32'h0000_0100);
        rc(8'h30, 32'h0001_1004);
        rc(8'h80, 32'h0000_0000);
        // park the unused buses on a quiet channel
        wr(8'h10, 32'h0007_E004);
        wr(8'h20, 32'h0007_E004);
        wr(8'h30, 32'h0007_E004);
        wr(OFS_RATE, 32'h0000_0000);
        rc(OFS_RATE, 32'h0000_012C);
        wr(OFS_RATE, 32'hFFFF_FFFF);
        rc(OFS_RATE, 32'h0131_2D00);
        wr(OFS_IDLE_GAP_GROUPING, 32'h0000_0000);
        rc(OFS_IDLE_GAP_GROUPING, 32'h0000_0001);
        wr(OFS_IDLE_GAP_GROUPING, 32'h00FF_FFFF);
        rc(OFS_IDLE_GAP_GROUPING, 32'h000F_4240);
        // 1e6 bps gives 50 clocks a bit, matching the model's bit time
        wr(OFS_RATE, 32'h000F_4240);
        wr(8'h14, 32'h000F_4240);
        wd(0, 9'h0A5, 8, -1, 2'h1, 1, OFS_LAST, 32'h0000_00A5);
        rc(OFS_STAT, 32'h0001_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0001);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFS_STAT, 32'h0000_0001);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0000_0000);
        rc(OFS_STAT, 32'h0001_0000);
        wr(OFS_STAT, 32'h0001_FFFF);
        wd(1, 9'h05A, 8, -1, 2'h1, 1, 8'h64, 32'h0000_005A);
        wr(OFS_CFG, 32'h0001_1005);
        wd(0, 9'h001, 8, -1, 2'h1, 1, OFS_LAST, 32'h0000_0080);
        for (int m = 1; m < 6; m++) begin
            wr(OFS_CFG, 32'h0001_1004 | (32'(m) << 3));
            wd(0, 9'h003, 8, pb[m], 2'h1, 1, OFS_LAST,
                {22'h00_0000, pe[m], 9'h003});
        end
        wr(OFS_CFG, 32'h0001_0A04);
        wd(0, 9'h015, 5, -1, 2'h1, 1, OFS_LAST, 32'h0000_0015);
        wr(OFS_CFG, 32'h0001_1204);
        wd(0, 9'h1A5, 9, -1, 2'h1, 1, OFS_LAST, 32'h0000_01A5);
        wr(OFS_CFG, 32'h0001_1214);
        rc(OFS_CFG, 32'h0001_1214);
        wr(OFS_CFG, 32'h0001_1004);
        wd(0, 9'h055, 8, -1, 2'h0, 1, OFS_LAST, 32'h0000_0255);
        wr(OFS_CFG, 32'h0001_1104);
        wd(0, 9'h055, 8, -1, 2'h1, 2, OFS_LAST, 32'h0000_0255);
        wd(0, 9'h055, 8, -1, 2'h3, 2, OFS_LAST, 32'h0000_0055);
        wr(OFS_CFG, 32'h0002_7004);
        wd(3, 9'h033, 8, -1, 2'h1, 1, OFS_LAST, 32'h0000_0033);
        wd(2, 9'h0C3, 8, -1, 2'h1, 1, 8'h64, 32'h0000_00C3);
        wr(8'h10, 32'h0001_9004);
        wd(4, 9'h07E, 8, -1, 2'h1, 1, 8'h68, 32'h0000_007E);
        // 5 us idle gap closes the long packet built up so far
        wr(OFS_CFG, 32'h0001_1004);
        wr(OFS_IDLE_GAP_GROUPING, 32'h0000_0005);
        wr(OFS_TRIG, 32'h0000_0102);
        wr(OFS_PAT, 32'h0000_0043);
        repeat (300) @(posedge hclk);
        wr(OFS_STAT, 32'h0001_FFFF);
        wd(0, 9'h043, 8, -1, 2'h1, 1, OFS_STAT, 32'h0000_0001);
        wd(0, 9'h043, 8, -1, 2'h1, 1, OFS_STAT, 32'h0001_0001);
        wr(OFS_CFG, 32'h0001_1002);
        wr(OFS_END_PATTERN_GROUPING, 32'h0000_0042);
        wr(OFS_TRIG, 32'h0000_0101);
        wr(OFS_STAT, 32'h0001_FFFF);
        wd(0, 9'h042, 8, -1, 2'h1, 1, OFS_STAT, 32'h0000_0001);
        wd(0, 9'h011, 8, -1, 2'h1, 1, OFS_STAT, 32'h0001_0001);
        wr(OFS_CFG, 32'h0001_1044);
        drv.idle(0, 1'b1);
        repeat (1000) @(posedge hclk);
        wr(OFS_STAT, 32'h0001_FFFF);
        wd(0, 9'h0A5, 8, -1, 2'h1, 1, OFS_LAST, 32'h0000_00A5);
        chk({31'h0, trig_seen}, 32'h0000_0001);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ===== testbench/uln_line_drv.sv
// uart line stimulus for the decoder's probe channels
`timescale 1ns/10ps
`default_nettype none
module uln_line_drv #(
    parameter int BIT_NS = 1000
) (
    // probe channel pins
    output logic [7:0] chan
);
    logic [7:0] inv = 8'h00;
    initial chan = 8'hFF;
    // one bit time at the logical level b
    task automatic put(input int ch, input logic b);
        chan[ch] = b ^ inv[ch];
        #BIT_NS;
    endtask
    // new polarity makes a glitch start edge; callers wait it out
    task automatic idle(input int ch, input logic low);
        inv[ch] = low;
        chan[ch] = ~low;
    endtask
    // wire order: start, data low bit first, parity, stops
    task automatic send(input int ch, input logic [8:0] v, input int nb,
            input int p, input logic [1:0] st, input int ns);
        put(ch, 1'b0);
        for (int i = 0; i < nb; i++) begin
            put(ch, v[i]);
        end
        if (p >= 0) begin
            put(ch, p[0]);
        end
        for (int i = 0; i < ns; i++) begin
            put(ch, st[i]);
        end
        chan[ch] = ~inv[ch];
    endtask
endmodule
`default_nettype wire
